//--- hw/pic_phy_irq_pd.v
`timescale 1ns/100ps
`include "pic_phy_regs.vh"

module pic_phy_irq_pd #(
    parameter PORT_B     = 0,
    parameter DELAY_CYC  = `PIC_LATE_DELAY_MS * `PIC_CLK_MHZ * 1000,
    parameter HOLD_CYC   = `PIC_LATE_HOLD_MS * `PIC_CLK_MHZ * 1000,
    parameter DROP_CYC   = `PIC_ENERGY_DROP_MS * `PIC_CLK_MHZ * 1000,
    parameter TXBASE_CYC = `PIC_TX_NLP_BASE_MS * `PIC_CLK_MHZ * 1000,
    parameter RXBASE_CYC = `PIC_RX_NLP_BASE_MS * `PIC_CLK_MHZ * 1000
) (
    input  wire        mclk_in,
    input  wire        rst_in,
    input  wire [7:0]  s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output wire        s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output wire        s_axi_wready_out,
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    input  wire [7:0]  s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output wire        s_axi_arready_out,
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    input  wire        internal_link_state_in,
    input  wire        line_signal_in,
    input  wire        normal_link_pulse_in,
    input  wire        an_complete_in,
    input  wire        remote_fault_in,
    input  wire        link_status_in,
    input  wire        lp_ack_in,
    input  wire        par_fault_in,
    input  wire        page_rx_in,
    input  wire [3:0]  wake_event_in,
    output reg         irq_out,
    output reg         xcvr_powerdown_out,
    output reg         xcvr_reset_out,
    output reg         tx_enable_out,
    output reg         rx_enable_out,
    output reg         nlp_tx_out,
    output reg         pme_req_out
);

    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_HOLD = 3'b100;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    reg [12:0] sync1_reg;
    reg [12:0] sync2_reg;
    reg        nlp_prev_reg;
    wire [12:0] raw_in = {wake_event_in, normal_link_pulse_in, line_signal_in, internal_link_state_in,
                          an_complete_in, remote_fault_in, link_status_in, lp_ack_in, par_fault_in,
                          page_rx_in};

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_reg    <= 13'h0000;
            sync2_reg    <= 13'h0000;
            nlp_prev_reg <= 1'b0;
        end else begin
            sync1_reg    <= raw_in;
            sync2_reg    <= sync1_reg;
            nlp_prev_reg <= sync2_reg[8];
        end
    end

    wire       sig_s    = sync2_reg[7];
    wire       nlp_edge = sync2_reg[8] & ~nlp_prev_reg;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [15:0] basic_control_reg;
    reg [15:0] mode_control_status_reg;
    reg [9:0]  interrupt_flag_reg;
    reg [9:0]  interrupt_mask_reg;
    reg [7:0]  wake_control_status_reg;
    reg [15:0] energy_detect_config_reg;
    reg [15:0] power_mgmt_control_reg;
    reg        line_energy_present;

    wire alternate_irq_select           = mode_control_status_reg[`PIC_MODE_ALT];
    wire general_powerdown_bit          = basic_control_reg[`PIC_BASIC_PWRDN];
    wire energy_detect_powerdown_enable = mode_control_status_reg[`PIC_MODE_ENERGY_DETECT_POWERDOWN_EN];
    wire wake_event_summary             = |(wake_control_status_reg[7:4] & wake_control_status_reg[3:0]);

    // ------------------------------------------------------------
    // axi4-lite slave, one write and one read in flight
    // ------------------------------------------------------------
    reg        aw_hold_reg;
    reg        w_hold_reg;
    reg [5:0]  aw_idx_reg;
    reg [31:0] wdata_reg;
    reg [3:0]  wstrb_reg;

    assign s_axi_awready_out = ~aw_hold_reg & ~s_axi_bvalid_out;
    assign s_axi_wready_out  = ~w_hold_reg & ~s_axi_bvalid_out;
    assign s_axi_arready_out = ~s_axi_rvalid_out;

    wire        wr_go = aw_hold_reg & w_hold_reg;
    wire [15:0] wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    wire [15:0] wd    = wdata_reg[15:0] & wmask;
    wire        wr_basic = wr_go & (aw_idx_reg == `PIC_IDX_BASIC);
    wire        wr_mode  = wr_go & (aw_idx_reg == `PIC_IDX_MODE);
    wire        wr_flag  = wr_go & (aw_idx_reg == `PIC_IDX_FLAG);
    wire        wr_mask  = wr_go & (aw_idx_reg == `PIC_IDX_MASK);
    wire        wr_wake  = wr_go & (aw_idx_reg == `PIC_IDX_WAKE);
    wire        wr_edcfg = wr_go & (aw_idx_reg == `PIC_IDX_EDCFG);
    wire        wr_pmt   = wr_go & (aw_idx_reg == `PIC_IDX_PMT);
    wire        wr_hit   = wr_basic | wr_mode | wr_flag | wr_mask | wr_wake | wr_edcfg | wr_pmt;

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_hold_reg      <= 1'b0;
            w_hold_reg       <= 1'b0;
            aw_idx_reg       <= 6'h00;
            wdata_reg        <= 32'h00000000;
            wstrb_reg        <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= 2'h0;
        end else begin
            if (s_axi_awvalid_in & s_axi_awready_out) begin
                aw_hold_reg <= 1'b1;
                aw_idx_reg  <= s_axi_awaddr_in[7:2];
            end
            if (s_axi_wvalid_in & s_axi_wready_out) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata_in;
                wstrb_reg  <= s_axi_wstrb_in;
            end
            if (wr_go) begin
                aw_hold_reg      <= 1'b0;
                w_hold_reg       <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= wr_hit ? 2'h0 : 2'h2;
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    reg [31:0] rd_mux;
    reg        rd_hit;
    always @* begin
        rd_hit = 1'b1;
        case (s_axi_araddr_in[7:2])
            `PIC_IDX_BASIC: rd_mux = {16'h0000, basic_control_reg};
            `PIC_IDX_MODE:  rd_mux = {16'h0000, mode_control_status_reg[15:2], line_energy_present,
                                      mode_control_status_reg[0]};
            `PIC_IDX_FLAG:  rd_mux = {22'h000000, interrupt_flag_reg};
            `PIC_IDX_MASK:  rd_mux = {22'h000000, interrupt_mask_reg};
            `PIC_IDX_WAKE:  rd_mux = {24'h000000, wake_control_status_reg};
            `PIC_IDX_EDCFG: rd_mux = {16'h0000, energy_detect_config_reg};
            `PIC_IDX_PMT:   rd_mux = {16'h0000, power_mgmt_control_reg};
            default: begin
                rd_mux = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= 32'h00000000;
            s_axi_rresp_out  <= 2'h0;
        end else if (s_axi_arvalid_in & s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out  <= rd_mux;
            s_axi_rresp_out  <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control registers; power-down never touches them
    // ------------------------------------------------------------
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            basic_control_reg        <= `PIC_ZERO16;
            mode_control_status_reg  <= `PIC_ZERO16;
            interrupt_mask_reg       <= 10'h000;
            energy_detect_config_reg <= `PIC_ZERO16;
            power_mgmt_control_reg   <= `PIC_ZERO16;
            wake_control_status_reg  <= 8'h00;
        end else begin
            if (wr_basic) basic_control_reg <= (basic_control_reg & ~wmask) | wd;
            if (wr_mode) mode_control_status_reg <= (mode_control_status_reg & ~wmask) | wd;
            if (wr_mask) interrupt_mask_reg <= (interrupt_mask_reg & ~wmask[9:0]) | {wd[9:1], 1'b0};
            if (wr_edcfg) energy_detect_config_reg <= (energy_detect_config_reg & ~wmask) | wd;
            if (wr_pmt) power_mgmt_control_reg <= (power_mgmt_control_reg & ~wmask) | wd;
            // event bits are write-one-clear, a fresh event wins
            wake_control_status_reg[3:0] <= wr_wake & wstrb_reg[0] ? wdata_reg[3:0] :
                                            wake_control_status_reg[3:0];
            wake_control_status_reg[7:4] <= sync2_reg[12:9] |
                (wake_control_status_reg[7:4] & ~({4{wr_wake & wstrb_reg[0]}} & wdata_reg[7:4]));
        end
    end

    // ------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------
    wire [9:0] src_now = {sync2_reg[6], wake_event_summary, line_energy_present, sync2_reg[5:0], 1'b0};
    reg  [9:0] src_prev_reg;
    wire [9:0] w1_hit = {10{wr_flag & alternate_irq_select}} & wmask[9:0] & wdata_reg[9:0];

    wire [9:0] flag_next;

    // per-bit next values only; one register process keeps a single driver per vector
    genvar gi;
    generate
        for (gi = 1; gi < 10; gi = gi + 1) begin : g_flag
            // link down asserts on a falling source, all others on a rising one
            wire cur  = (gi == 4) ? ~src_now[gi] : src_now[gi];
            wire prev = (gi == 4) ? ~src_prev_reg[gi] : src_prev_reg[gi];
            wire set_ev   = cur & ~prev;
            wire clr_prim = ~cur & prev;
            wire clr_alt  = w1_hit[gi] & ~cur;
            // a fresh assert edge beats a clear in the same cycle
            assign flag_next[gi] = set_ev |
                (interrupt_flag_reg[gi] & ~(alternate_irq_select ? clr_alt : clr_prim));
        end
    endgenerate

    // bit 0 has no source and always reads zero
    assign flag_next[0] = 1'b0;

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            interrupt_flag_reg <= `PIC_FLAG_RST;
            src_prev_reg       <= `PIC_FLAG_RST;
        end else begin
            interrupt_flag_reg <= flag_next;
            src_prev_reg       <= src_now;
        end
    end

    // ------------------------------------------------------------
    // line energy and link pulse wake
    // ------------------------------------------------------------
    reg [27:0] drop_cnt_reg;
    reg [27:0] rxwin_cnt_reg;
    wire [1:0] rx_sel  = energy_detect_config_reg[`PIC_ED_RX_SEL_LO +: 2];
    wire [27:0] rx_win = RXBASE_CYC[27:0] << rx_sel;
    wire nlp_wake = nlp_edge & (energy_detect_config_reg[`PIC_ED_SINGLE] | (rxwin_cnt_reg != 28'h0));

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            line_energy_present <= 1'b1;
            drop_cnt_reg        <= 28'h0;
            rxwin_cnt_reg       <= 28'h0;
        end else begin
            // a lone pulse opens the window for the second one
            if (nlp_edge & ~nlp_wake)
                rxwin_cnt_reg <= rx_win;
            else if (nlp_wake)
                rxwin_cnt_reg <= 28'h0;
            else if (rxwin_cnt_reg != 28'h0)
                rxwin_cnt_reg <= rxwin_cnt_reg - 28'h1;
            if (sig_s | nlp_wake) begin
                line_energy_present <= 1'b1;
                drop_cnt_reg        <= 28'h0;
            end else if (line_energy_present) begin
                if (drop_cnt_reg == DROP_CYC[27:0] - 28'h1) begin
                    line_energy_present <= 1'b0;
                    drop_cnt_reg        <= 28'h0;
                end else begin
                    drop_cnt_reg <= drop_cnt_reg + 28'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // late energy interrupt after cable removal
    // ------------------------------------------------------------
    reg [2:0]  late_st_reg;
    reg [27:0] late_cnt_reg;
    reg        late_arm_reg;
    wire energy_fall = src_prev_reg[7] & ~line_energy_present;

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            late_st_reg  <= ST_IDLE;
            late_cnt_reg <= 28'h0;
            late_arm_reg <= 1'b0;
        end else begin
            // arms once the flag was cleared with energy still up
            if (~interrupt_mask_reg[7])
                late_arm_reg <= 1'b0;
            else if (line_energy_present & ~interrupt_flag_reg[7])
                late_arm_reg <= 1'b1;
            else if (energy_fall)
                late_arm_reg <= 1'b0;
            case (late_st_reg)
                ST_IDLE: begin
                    late_cnt_reg <= 28'h0;
                    if (energy_fall & late_arm_reg & interrupt_mask_reg[7])
                        late_st_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    late_cnt_reg <= late_cnt_reg + 28'h1;
                    if (~interrupt_mask_reg[7]) begin
                        late_st_reg <= ST_IDLE;
                    end else if (late_cnt_reg == DELAY_CYC[27:0] - 28'h1) begin
                        late_st_reg  <= ST_HOLD;
                        late_cnt_reg <= 28'h0;
                    end
                end
                ST_HOLD: begin
                    late_cnt_reg <= late_cnt_reg + 28'h1;
                    if (~interrupt_mask_reg[7] | (late_cnt_reg == HOLD_CYC[27:0] - 28'h1))
                        late_st_reg <= ST_IDLE;
                end
                default: late_st_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // power-down control and outputs
    // ------------------------------------------------------------
    reg [4:0]  rst_cnt_reg;
    reg [27:0] tx_cnt_reg;
    wire       energy_detect_powerdown_active = energy_detect_powerdown_enable & ~line_energy_present;
    wire       pd_next     = general_powerdown_bit | energy_detect_powerdown_active;
    // any return from power-down, general or energy wake, passes the automatic reset
    wire       pd_fall     = xcvr_powerdown_out & ~pd_next;
    wire [1:0] tx_sel      = energy_detect_config_reg[`PIC_ED_TX_SEL_LO +: 2];
    wire       tx_nlp_on   = energy_detect_powerdown_active & ~general_powerdown_bit & energy_detect_config_reg[`PIC_ED_TX_EN];
    wire       pmt_en      = power_mgmt_control_reg[`PIC_PMT_ED_EN_A + ((PORT_B != 0) ? 1 : 0)];
    wire       ed_wake     = energy_detect_powerdown_enable & line_energy_present & ~src_prev_reg[7];

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rst_cnt_reg        <= 5'h00;
            tx_cnt_reg         <= 28'h0;
            irq_out            <= 1'b0;
            xcvr_powerdown_out <= 1'b0;
            xcvr_reset_out     <= 1'b0;
            tx_enable_out      <= 1'b0;
            rx_enable_out      <= 1'b0;
            nlp_tx_out         <= 1'b0;
            pme_req_out        <= 1'b0;
        end else begin
            if (pd_fall)
                rst_cnt_reg <= `PIC_AUTO_RST_CYC;
            else if (rst_cnt_reg != 5'h00)
                rst_cnt_reg <= rst_cnt_reg - 5'h01;
            xcvr_reset_out     <= pd_fall | (rst_cnt_reg > 5'h01);
            irq_out            <= (|(interrupt_flag_reg & interrupt_mask_reg)) | late_st_reg[2];
            xcvr_powerdown_out <= pd_next;
            tx_enable_out      <= ~pd_next;
            // receive path is gated during power-down, so waking traffic can be lost
            rx_enable_out      <= ~pd_next;
            if (tx_nlp_on & (tx_cnt_reg == 28'h0)) begin
                tx_cnt_reg <= (TXBASE_CYC[27:0] << tx_sel) - 28'h1;
                nlp_tx_out <= 1'b1;
            end else begin
                tx_cnt_reg <= tx_nlp_on ? tx_cnt_reg - 28'h1 : 28'h0;
                nlp_tx_out <= 1'b0;
            end
            pme_req_out <= ed_wake & pmt_en;
        end
    end

endmodule

//--- hw/pic_phy_regs.vh
`ifndef PIC_PHY_REGS_VH
`define PIC_PHY_REGS_VH

// register indices, byte address is four times the index
`define PIC_IDX_BASIC       6'h00
`define PIC_IDX_WAKE        6'h10
`define PIC_IDX_MODE        6'h11
`define PIC_IDX_EDCFG       6'h1b
`define PIC_IDX_FLAG        6'h1d
`define PIC_IDX_MASK        6'h1e
`define PIC_IDX_PMT         6'h28

// field positions
`define PIC_BASIC_PWRDN     11
`define PIC_MODE_ENERGY_DETECT_POWERDOWN_EN    13
`define PIC_MODE_ALT        6
`define PIC_MODE_ENERGY     1
`define PIC_ED_TX_EN        0
`define PIC_ED_TX_SEL_LO    1
`define PIC_ED_SINGLE       3
`define PIC_ED_RX_SEL_LO    4
`define PIC_PMT_ED_EN_A     14

// reset values
`define PIC_FLAG_RST        10'h080
`define PIC_ZERO16          16'h0000

// timing
`define PIC_CLK_MHZ         250
`define PIC_LATE_DELAY_MS   1000
`define PIC_LATE_HOLD_MS    256
`define PIC_ENERGY_DROP_MS  4
`define PIC_TX_NLP_BASE_MS  128
`define PIC_RX_NLP_BASE_MS  16
`define PIC_AUTO_RST_CYC    5'h10

`endif

//--- sim/pic_irq_props.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checker
// ----------------------------------------
module pic_irq_props (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic xcvr_powerdown_out,
    input wire logic xcvr_reset_out,
    input wire logic tx_enable_out,
    input wire logic rx_enable_out,
    input wire logic nlp_tx_out,
    input wire logic pme_req_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence wr_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence pd_release;
        $fell(xcvr_powerdown_out);
    endsequence
    write_answer_a: assert property (wr_taken |=> ##1 s_axi_bvalid_out)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read response late");
    pd_silent_a: assert property (xcvr_powerdown_out [*2] |-> !tx_enable_out && !rx_enable_out)
        else $error("transmit alive while powered down");
    power_up_a: assert property ((!xcvr_powerdown_out) [*3] |-> tx_enable_out && rx_enable_out)
        else $error("transceiver not back up");
    auto_reset_a: assert property (pd_release |-> ##[0:2] xcvr_reset_out)
        else $error("no reset after power up");
    nlp_pulse_a: assert property (nlp_tx_out |=> !nlp_tx_out)
        else $error("link pulse longer than one cycle");
    nlp_in_pd_a: assert property (nlp_tx_out |-> xcvr_powerdown_out)
        else $error("link pulse outside power-down");
    pme_pulse_a: assert property (pme_req_out |=> !pme_req_out)
        else $error("power event longer than one cycle");
endmodule

bind pic_phy_irq_pd pic_irq_props u_props (.*);

//--- sim/pic_link_partner.sv
`timescale 1ns/100ps
// ----------------------------------------
// far-side cable model
// ----------------------------------------
module pic_link_partner (
    input  wire logic mclk_in,
    output logic      line_signal_out,
    output logic      link_pulse_out
);
    initial begin
        line_signal_out = 1'b0;
        link_pulse_out  = 1'b0;
    end
    // steady line activity, as from packets on the cable
    task automatic set_line(input logic v);
        line_signal_out <= v;
    endtask
    // gap of at least one cycle keeps pulses apart so each is seen as its own edge
    task automatic send_pulses(input int n, input int gap);
        repeat (n) begin
            link_pulse_out <= 1'b1;
            @(posedge mclk_in);
            link_pulse_out <= 1'b0;
            repeat (gap) @(posedge mclk_in);
        end
    endtask
endmodule

//--- sim/pic_phy_irq_pd_tb.sv
`timescale 1ns/100ps
`include "pic_phy_regs.vh"
// ----------------------------------------
// testbench
// ----------------------------------------
module pic_phy_irq_pd_tb;
    localparam [7:0] A_BASIC = {`PIC_IDX_BASIC, 2'b00}, A_WAKE = {`PIC_IDX_WAKE, 2'b00};
    localparam [7:0] A_MODE = {`PIC_IDX_MODE, 2'b00}, A_EDCFG = {`PIC_IDX_EDCFG, 2'b00};
    localparam [7:0] A_FLAG = {`PIC_IDX_FLAG, 2'b00}, A_MASK = {`PIC_IDX_MASK, 2'b00}, A_PMT = {`PIC_IDX_PMT, 2'b00};
    logic        mclk_in = 1'b0, rst_in = 1'b1;
    logic [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0, d;
    logic [3:0]  s_axi_wstrb_in = 4'hf, wake_event_in = 4'h0;
    logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_arvalid_in = 1'b0;
    logic        s_axi_bready_in = 1'b1, s_axi_rready_in = 1'b1;
    logic [9:1]  src = 9'h008;
    logic [1:0]  r;
    wire  [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    wire  [31:0] s_axi_rdata_out;
    wire         s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    wire         irq_out, xcvr_powerdown_out, xcvr_reset_out, tx_enable_out, rx_enable_out, nlp_tx_out, pme_req_out;
    wire         line_signal_in, normal_link_pulse_in;
    wire         internal_link_state_in = src[9], an_complete_in = src[6], remote_fault_in = src[5];
    wire         link_status_in = src[4], lp_ack_in = src[3], par_fault_in = src[2], page_rx_in = src[1];
    int          failures = 0, tests_run = 0, nlp_cnt = 0, pme_cnt = 0;

    pic_phy_irq_pd #(.DELAY_CYC(40), .HOLD_CYC(20), .DROP_CYC(30), .TXBASE_CYC(50), .RXBASE_CYC(20)) u_dut (.*);
    pic_link_partner lp (.mclk_in(mclk_in), .line_signal_out(line_signal_in), .link_pulse_out(normal_link_pulse_in));

    initial forever #2 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        if (nlp_tx_out === 1'b1) nlp_cnt++;
        if (pme_req_out === 1'b1) pme_cnt++;
    end

    task automatic chk(input [31:0] exp, input [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic axi_wr(input [7:0] a, input [31:0] v);
        s_axi_awaddr_in  <= a;
        s_axi_wdata_in   <= v;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in  <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while ((s_axi_awvalid_in && !s_axi_awready_out) || (s_axi_wvalid_in && !s_axi_wready_out));
        do @(posedge mclk_in); while (s_axi_bvalid_out !== 1'b1);
        r = s_axi_bresp_out;
    endtask
    task automatic axi_rd(input [7:0] a);
        s_axi_araddr_in  <= a;
        s_axi_arvalid_in <= 1'b1;
        do @(posedge mclk_in); while (s_axi_arready_out !== 1'b1);
        s_axi_arvalid_in <= 1'b0;
        do @(posedge mclk_in); while (s_axi_rvalid_out !== 1'b1);
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
    endtask
    task automatic rd_chk(input [7:0] a, input [31:0] exp);
        axi_rd(a);
        chk(exp, d);
    endtask
    task automatic print_verdict;
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_in);
        failures++;
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        rd_chk(A_FLAG, 32'h080);
        rd_chk(A_MODE, 32'h002);
        axi_rd(8'hfc);
        chk(32'h2, r);
        axi_wr(8'hfc, 32'h0);
        chk(32'h2, r);
        repeat (40) @(posedge mclk_in);
        rd_chk(A_FLAG, 32'h0);
        rd_chk(A_MODE, 32'h0);
        $display("test reset done");
        axi_wr(A_MASK, 32'h3fe);
        for (int i = 1; i < 10; i++) begin
            if (i == 7 || i == 8) continue;
            src[i] <= ~src[i];
            repeat (6) @(posedge mclk_in);
            rd_chk(A_FLAG, 32'h1 << i);
            chk(1, irq_out);
            src[i] <= ~src[i];
            repeat (6) @(posedge mclk_in);
            rd_chk(A_FLAG, 32'h0);
            chk(0, irq_out);
        end
        $display("test sources done");
        axi_wr(A_MASK, 32'h100);
        axi_wr(A_WAKE, 32'h2);
        wake_event_in <= 4'h1;
        repeat (6) @(posedge mclk_in);
        chk(0, irq_out);
        wake_event_in <= 4'h2;
        repeat (6) @(posedge mclk_in);
        rd_chk(A_WAKE, 32'h32);
        chk(1, irq_out);
        wake_event_in <= 4'h0;
        // events are sticky, so the synchroniser must drain before the clear
        repeat (4) @(posedge mclk_in);
        axi_wr(A_WAKE, 32'h32);
        repeat (4) @(posedge mclk_in);
        chk(0, irq_out);
        $display("test wake done");
        axi_wr(A_MASK, 32'h002);
        axi_wr(A_MODE, 32'h040);
        src[1] <= 1'b1;
        repeat (6) @(posedge mclk_in);
        axi_wr(A_FLAG, 32'h002);
        rd_chk(A_FLAG, 32'h002);
        src[1] <= 1'b0;
        repeat (6) @(posedge mclk_in);
        rd_chk(A_FLAG, 32'h002);
        chk(1, irq_out);
        axi_wr(A_FLAG, 32'h002);
        rd_chk(A_FLAG, 32'h0);
        chk(0, irq_out);
        axi_wr(A_MODE, 32'h0);
        $display("test alternate done");
        axi_wr(A_BASIC, 32'h800);
        repeat (3) @(posedge mclk_in);
        chk(1, xcvr_powerdown_out);
        chk(0, tx_enable_out);
        chk(0, rx_enable_out);
        axi_wr(A_BASIC, 32'h0);
        repeat (3) @(posedge mclk_in);
        chk(0, xcvr_powerdown_out);
        chk(1, xcvr_reset_out);
        rd_chk(A_MASK, 32'h002);
        $display("test powerdown done");
        axi_wr(A_PMT, 32'h4000);
        axi_wr(A_EDCFG, 32'h1);
        axi_wr(A_MODE, 32'h2000);
        repeat (120) @(posedge mclk_in);
        chk(1, xcvr_powerdown_out);
        chk(1, nlp_cnt > 0);
        lp.send_pulses(1, 60);
        chk(1, xcvr_powerdown_out);
        lp.send_pulses(2, 5);
        repeat (8) @(posedge mclk_in);
        chk(0, xcvr_powerdown_out);
        chk(1, pme_cnt);
        rd_chk(A_FLAG, 32'h080);
        repeat (40) @(posedge mclk_in);
        chk(1, xcvr_powerdown_out);
        axi_wr(A_EDCFG, 32'h9);
        lp.send_pulses(1, 8);
        chk(0, xcvr_powerdown_out);
        chk(2, pme_cnt);
        lp.set_line(1'b1);
        repeat (50) @(posedge mclk_in);
        rd_chk(A_MODE, 32'h2002);
        chk(0, xcvr_powerdown_out);
        $display("test energy detect done");
        print_verdict();
    end
endmodule
